// ### hdl/pcp_parallel_config_port.sv
// byte-wide parallel configuration port, device end
`timescale 1ns/100ps
`include "pcp_defs.svh"

// How it works
// - config clock paces loading; input in slave mode, driven out in master mode.
// - low full_reset_n resets the whole port asynchronously; pin idles high.
// - init is an input before mode sampling; held low it delays configuration.
// - after mode sampling, init is open-drain: low means CRC error.
// - done is high once configuration completed, low before.
// - data line 0 carries the most significant bit of each byte.
// - read_not_write low means host writes; high means device drives readback.
// - device neither drives nor samples data while chip select is high.
// - in master mode the device makes the config clock timing all transfers.
// - first byte taken on first edge with init high, select and write low.
// - read_not_write change while selected aborts the transfer.
// - done is open-drain by default; an active driver may be enabled.
// - enable the active done driver only on the chain's last device.
// - the startup sequence is clocked by the config clock.
// - data present while busy is high is ignored.
// - during readback busy low marks cycles carrying valid data.
// - chip select high disables the port at once; data and busy float.
module pcp_parallel_config_port (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       full_reset_n_i,
    input  wire logic       config_clock_i,
    output logic            config_clock_o,
    output logic            config_clock_oe_o,
    input  wire logic       cs_n_i,
    input  wire logic       read_not_write_i,
    input  wire logic       mode_master_i,
    input  wire logic       init_i,
    output logic            init_o,
    output logic            init_oe_o,
    output logic            done_o,
    output logic            done_oe_o,
    input  wire logic       complete_active_driver_i,
    output logic            busy_o,
    output logic            busy_oe_o,
    input  wire logic [7:0] data_i,
    output logic      [7:0] data_o,
    output logic            data_oe_o,
    output logic      [7:0] cfg_byte_o,
    output logic            cfg_valid_o,
    input  wire logic       cfg_ready_i,
    input  wire logic       cfg_end_i,
    input  wire logic       crc_error_i,
    input  wire logic [7:0] rb_data_i,
    input  wire logic       rb_valid_i,
    output logic            rb_ready_o,
    output logic            abort_o,
    output logic            master_mode_o
);

    typedef struct packed {
        pcp_pkg::pcp_state_type state;
        logic [3:0]             cnt;
        logic [2:0]             div;
        logic                   config_clock_out;
        logic                   config_clock_prev;
        logic                   master;
        logic                   rnw_seen;
        logic                   done;
        logic                   crc_err;
        logic [7:0]             rb_data;
        logic                   rb_have;
        logic                   abort;
    } pcp_core_type;

    pcp_core_type                 st;
    pcp_core_type                 next_st;
    logic                         core_rst_n;
    logic [`PCP_SYNC_W-1:0]       sync_s;
    logic                         config_clock_s;
    logic                         cs_n_s;
    logic                         rnw_s;
    logic                         init_s;
    logic                         mode_s;
    logic [7:0]                   data_s;
    logic                         running;
    logic                         config_clock_rise;
    logic                         selected;
    logic                         push;
    logic                         fifo_ready;

    // line 0 is the msb on the pins, so bytes are mirrored at the boundary
    function automatic logic [7:0] pcp_mirror(input logic [7:0] b);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7-i];
        end
        return r;
    endfunction : pcp_mirror

    // reset pin is not synchronised on release; the host holds it for many clocks
    assign core_rst_n = rst_n_i && full_reset_n_i;

    pcp_sync #(
        .WIDTH (`PCP_SYNC_W)
    ) u_sync (
        .clk_i   (mclk_i),
        .rst_n_i (core_rst_n),
        .async_i ({config_clock_i, cs_n_i, read_not_write_i, init_i, mode_master_i, data_i}),
        .sync_o  (sync_s)
    );

    assign config_clock_s   = sync_s[`PCP_SI_CONFIG_CLOCK];
    assign cs_n_s   = sync_s[`PCP_SI_CS_N];
    assign rnw_s    = sync_s[`PCP_SI_RNW];
    assign init_s   = sync_s[`PCP_SI_INIT];
    assign mode_s   = sync_s[`PCP_SI_MODE];
    assign data_s   = sync_s[`PCP_SI_DATA_HI:`PCP_SI_DATA_LO];
    assign selected = !cs_n_s;

    assign running = (st.state != pcp_pkg::PCP_CLEAR) && (st.state != pcp_pkg::PCP_WAIT_INIT);

    // one event per config clock rising edge, own or received
    assign config_clock_rise = st.master ? (running && (st.div == `PCP_CONFIG_CLOCK_HALF - 3'h1) && !st.config_clock_out)
                                 : (config_clock_s && !st.config_clock_prev);

    // bytes refused by a full buffer are dropped; busy tells the host to repeat
    assign push = config_clock_rise && selected && !rnw_s && fifo_ready && !cfg_end_i
               && ((st.state == pcp_pkg::PCP_IDLE) || (st.state == pcp_pkg::PCP_WRITE));

    pcp_fifo #(
        .WIDTH (`PCP_BYTE_W),
        .DEPTH (`PCP_FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (mclk_i),
        .rst_n_i     (core_rst_n),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (pcp_mirror(data_s)),
        .out_valid_o (cfg_valid_o),
        .out_ready_i (cfg_ready_i),
        .out_data_o  (cfg_byte_o)
    );

    assign rb_ready_o = (st.state == pcp_pkg::PCP_READ) && config_clock_rise && selected && rnw_s
                     && (rnw_s == st.rnw_seen);

    always_comb begin
        next_st           = st;
        next_st.abort     = 1'b0;
        next_st.config_clock_prev = config_clock_s;
        if (st.master && running) begin
            if (st.div == `PCP_CONFIG_CLOCK_HALF - 3'h1) begin
                next_st.div      = '0;
                next_st.config_clock_out = !st.config_clock_out;
            end else begin
                next_st.div = st.div + 3'h1;
            end
        end
        if (running && crc_error_i) begin
            next_st.crc_err = 1'b1;
        end
        unique case (st.state)
            pcp_pkg::PCP_CLEAR: begin
                // count starts at zero under reset, so this gives the full clear span after release
                if (st.cnt == `PCP_CLEAR_CYCLES) begin
                    next_st.cnt   = '0;
                    next_st.state = pcp_pkg::PCP_WAIT_INIT;
                end else begin
                    next_st.cnt = st.cnt + 4'h1;
                end
            end
            pcp_pkg::PCP_WAIT_INIT: begin
                // mode is caught as init rises; a low init from outside holds us here
                if (init_s) begin
                    next_st.master = mode_s;
                    next_st.state  = pcp_pkg::PCP_IDLE;
                end
            end
            pcp_pkg::PCP_IDLE: begin
                if (config_clock_rise && selected) begin
                    next_st.rnw_seen = rnw_s;
                    next_st.rb_have  = 1'b0;
                    next_st.state    = rnw_s ? pcp_pkg::PCP_READ : pcp_pkg::PCP_WRITE;
                end
            end
            pcp_pkg::PCP_WRITE: begin
                if (!selected) begin
                    next_st.state = pcp_pkg::PCP_IDLE;
                end else if (config_clock_rise && (rnw_s != st.rnw_seen)) begin
                    next_st.abort = 1'b1;
                    next_st.state = pcp_pkg::PCP_ABORT;
                end else if (config_clock_rise && cfg_end_i) begin
                    next_st.cnt   = '0;
                    next_st.state = pcp_pkg::PCP_STARTUP;
                end
            end
            pcp_pkg::PCP_READ: begin
                if (!selected) begin
                    next_st.state = pcp_pkg::PCP_IDLE;
                end else if (config_clock_rise && (rnw_s != st.rnw_seen)) begin
                    next_st.abort = 1'b1;
                    next_st.state = pcp_pkg::PCP_ABORT;
                end else if (config_clock_rise) begin
                    // host takes the shown byte on this edge; refill or show busy
                    next_st.rb_have = rb_valid_i;
                    if (rb_valid_i) begin
                        next_st.rb_data = pcp_mirror(rb_data_i);
                    end
                end
            end
            pcp_pkg::PCP_ABORT: begin
                if (!selected) begin
                    next_st.state = pcp_pkg::PCP_IDLE;
                end
            end
            pcp_pkg::PCP_STARTUP: begin
                if (config_clock_rise) begin
                    if (st.cnt == `PCP_STARTUP_CYCLES - 4'h1) begin
                        next_st.done  = 1'b1;
                        next_st.state = pcp_pkg::PCP_IDLE;
                    end else begin
                        next_st.cnt = st.cnt + 4'h1;
                    end
                end
            end
            default: begin
                next_st.state = pcp_pkg::PCP_CLEAR;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge core_rst_n) begin
        if (!core_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign config_clock_o    = st.config_clock_out;
    assign config_clock_oe_o = st.master && running;
    assign master_mode_o     = st.master;

    // init pulled low while clearing, then only to flag a CRC error
    assign init_o    = 1'b0;
    assign init_oe_o = ((st.state == pcp_pkg::PCP_CLEAR) && (st.cnt != '0)) || (running && st.crc_err);

    // open drain unless the active driver is strapped on (last device only)
    assign done_o    = st.done;
    assign done_oe_o = !st.done || complete_active_driver_i;

    // enables use the raw select pin so deselect floats the bus at once
    assign busy_oe_o = !cs_n_i && running;
    assign busy_o    = (st.state == pcp_pkg::PCP_READ) ? !st.rb_have
                     : ((st.state == pcp_pkg::PCP_IDLE) || (st.state == pcp_pkg::PCP_WRITE)) ? !fifo_ready
                     : 1'b1;
    assign data_oe_o = !cs_n_i && (st.state == pcp_pkg::PCP_READ);
    assign data_o    = st.rb_data;
    assign abort_o   = st.abort;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!core_rst_n);

    sequence s_write_edge;
        (st.state == pcp_pkg::PCP_WRITE) && selected && config_clock_rise;
    endsequence

    sequence s_dir_flip;
        rnw_s != st.rnw_seen;
    endsequence

    a_float_deselect: assert property (cs_n_i |-> !data_oe_o && !busy_oe_o)
        else $error("data or busy driven while deselected");
    a_no_sample_deselect: assert property (push |-> selected && !rnw_s)
        else $error("byte taken while deselected or reading");
    a_busy_ignores_data: assert property (push |-> !busy_o)
        else $error("byte taken while busy");
    a_dir_abort: assert property ((s_write_edge and s_dir_flip) |=> abort_o && (st.state == pcp_pkg::PCP_ABORT))
        else $error("direction change did not abort");
    a_init_holds: assert property ((st.state == pcp_pkg::PCP_WAIT_INIT) && !init_s |=> !running)
        else $error("configuration started with init held low");
    a_crc_init_low: assert property (running && st.crc_err |-> init_oe_o && !init_o)
        else $error("crc error not shown on init");
    a_done_startup: assert property ($rose(st.done) |-> $past(st.state) == pcp_pkg::PCP_STARTUP
                                     && $past(st.cnt) == `PCP_STARTUP_CYCLES - 4'h1)
        else $error("done rose outside a full startup");
    a_done_drive: assert property (st.done && !complete_active_driver_i |-> !done_oe_o)
        else $error("done driven high without active driver");
    a_master_clock: assert property (st.master && running && $rose(config_clock_o)
                                     |=> $stable(config_clock_o)[*3] ##1 $fell(config_clock_o))
        else $error("master config clock half period wrong");
    a_slave_no_drive: assert property (!st.master |-> !config_clock_oe_o)
        else $error("config clock driven in slave mode");
    a_first_byte: assert property ((st.state == pcp_pkg::PCP_IDLE) && config_clock_rise && selected && !rnw_s
                                   && fifo_ready && !cfg_end_i |-> push ##1 (st.state == pcp_pkg::PCP_WRITE))
        else $error("first byte not taken");

endmodule : pcp_parallel_config_port

// ### hdl/pcp_defs.svh
// constants of the parallel configuration port
`ifndef PCP_DEFS_SVH
`define PCP_DEFS_SVH

`define PCP_BYTE_W          8
`define PCP_FIFO_DEPTH      8
`define PCP_SYNC_W          13

// synchroniser lane positions
`define PCP_SI_CONFIG_CLOCK         12
`define PCP_SI_CS_N         11
`define PCP_SI_RNW          10
`define PCP_SI_INIT         9
`define PCP_SI_MODE         8
`define PCP_SI_DATA_HI      7
`define PCP_SI_DATA_LO      0

// timing: master config clock half period, derived from the system clock
`define PCP_MCLK_NS         100
`define PCP_CONFIG_CLOCK_HALF_NS    400
`define PCP_CONFIG_CLOCK_HALF       (3'((`PCP_CONFIG_CLOCK_HALF_NS + `PCP_MCLK_NS - 1) / `PCP_MCLK_NS))

// cycles the init pin is held low after reset, counted on the system clock
`define PCP_CLEAR_CYCLES    4'h8
// least number of config clock rising edges in the startup sequence
`define PCP_STARTUP_CYCLES  4'h8

`endif

// ### hdl/pcp_pkg.sv
// types shared by the parallel configuration port files
package pcp_pkg;

    typedef enum logic [3:0] {
        PCP_CLEAR     = 4'h0,
        PCP_WAIT_INIT = 4'h1,
        PCP_IDLE      = 4'h2,
        PCP_WRITE     = 4'h3,
        PCP_READ      = 4'h4,
        PCP_ABORT     = 4'h5,
        PCP_STARTUP   = 4'h6
    } pcp_state_type;

endpackage : pcp_pkg

// ### hdl/pcp_sync.sv
// two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/100ps

module pcp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } pcp_sync_type;

    pcp_sync_type st;
    pcp_sync_type next_st;

    always_comb begin
        next_st        = st;
        next_st.stage1 = async_i;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_o = st.stage2;

endmodule : pcp_sync

// ### hdl/pcp_fifo.sv
// flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps

module pcp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
    } pcp_fifo_type;

    pcp_fifo_type st;
    pcp_fifo_type next_st;
    logic         push;
    logic         pop;

    assign in_ready_o  = (st.count != (AW+1)'(DEPTH));
    assign out_valid_o = (st.count != '0);
    assign out_data_o  = st.mem[st.rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr_ptr] = in_data_i;
            next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0 : st.wr_ptr + AW'(1);
        end
        if (pop) begin
            next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH - 1)) ? '0 : st.rd_ptr + AW'(1);
        end
        if (push && !pop) begin
            next_st.count = st.count + (AW+1)'(1);
        end else if (pop && !push) begin
            next_st.count = st.count - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : pcp_fifo

// ### bench/pcp_host_model.sv
// host side model: drives the slave pins and resolves the shared wires
`timescale 1ns/100ps

module pcp_host_model (
    input  wire logic       mclk_i,
    input  wire logic       dev_clk_i,
    input  wire logic       dev_clk_oe_i,
    input  wire logic [7:0] dev_data_i,
    input  wire logic       dev_data_oe_i,
    input  wire logic       dev_init_oe_i,
    output logic            clk_pin_o,
    output logic            cs_n_o,
    output logic            rnw_o,
    output logic      [7:0] data_pin_o,
    output logic            init_pin_o
);
    // 4 mclk per phase: 1.25 MHz, far under the unhandshaked limit
    localparam int HALF = 4;
    logic       host_clk  = 1'b0;
    logic       cs_q      = 1'b1;
    logic       rnw_q     = 1'b0;
    logic       drv       = 1'b0;
    logic [7:0] dat       = 8'h00;
    logic       hold_init = 1'b0;

    assign clk_pin_o  = dev_clk_oe_i ? dev_clk_i : host_clk;
    assign cs_n_o     = cs_q;
    assign rnw_o      = rnw_q;
    // released lines show the inverse of the last value, not a stale copy
    assign data_pin_o = dev_data_oe_i ? dev_data_i : (drv ? dat : ~dat);
    assign init_pin_o = !(dev_init_oe_i || hold_init);

    task automatic sel(input logic cs_n, input logic rnw, input logic [7:0] d);
        @(posedge mclk_i);
        #10;
        cs_q  = cs_n;
        rnw_q = rnw;
        dat   = d;
        drv   = !cs_n && !rnw;
    endtask : sel

    // clock stands low outside transfers
    task automatic tick();
        repeat (HALF) @(posedge mclk_i);
        #10;
        host_clk = 1'b1;
        repeat (HALF) @(posedge mclk_i);
        #10;
        host_clk = 1'b0;
    endtask : tick
endmodule : pcp_host_model

// ### bench/pcp_parallel_config_port_test.sv
// self-checking bench of the parallel configuration port
`timescale 1ns/100ps

module pcp_parallel_config_port_test;
    localparam int DLY = 10;
    logic       mclk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       full_reset_n_i = 1'b1;
    logic       mode_master_i = 1'b0;
    logic       complete_active_driver_i = 1'b0;
    logic       cfg_ready_i = 1'b0;
    logic       cfg_end_i = 1'b0;
    logic       crc_error_i = 1'b0;
    logic       rb_valid_i = 1'b0;
    logic [7:0] rb_data_i = 8'h00;
    logic       config_clock_i, config_clock_o, config_clock_oe_o, cs_n_i, read_not_write_i;
    logic       init_i, init_o, init_oe_o, done_o, done_oe_o, busy_o, busy_oe_o, data_oe_o;
    logic       cfg_valid_o, rb_ready_o, abort_o, master_mode_o;
    logic [7:0] data_i, data_o, cfg_byte_o;
    int         n_mismatch = 0;
    int         num_checks = 0;
    int         n_abort = 0;
    int         n_rb_take = 0;

    pcp_parallel_config_port pcp_parallel_config_port_inst (
        .mclk_i, .rst_n_i, .full_reset_n_i, .config_clock_i, .config_clock_o, .config_clock_oe_o,
        .cs_n_i, .read_not_write_i, .mode_master_i, .init_i, .init_o, .init_oe_o, .done_o, .done_oe_o,
        .complete_active_driver_i, .busy_o, .busy_oe_o, .data_i, .data_o, .data_oe_o, .cfg_byte_o,
        .cfg_valid_o, .cfg_ready_i, .cfg_end_i, .crc_error_i, .rb_data_i, .rb_valid_i, .rb_ready_o,
        .abort_o, .master_mode_o);

    pcp_host_model pcp_host_model_inst (
        .mclk_i(mclk_i), .dev_clk_i(config_clock_o), .dev_clk_oe_i(config_clock_oe_o),
        .dev_data_i(data_o), .dev_data_oe_i(data_oe_o), .dev_init_oe_i(init_oe_o),
        .clk_pin_o(config_clock_i), .cs_n_o(cs_n_i), .rnw_o(read_not_write_i),
        .data_pin_o(data_i), .init_pin_o(init_i));

    initial begin
        forever #50 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i) begin
        if (abort_o === 1'b1) n_abort <= n_abort + 1;
    end

    always @(posedge mclk_i) begin
        if (rb_ready_o === 1'b1) n_rb_take <= n_rb_take + 1;
    end

    task automatic chk1(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chkn(input string what, input int exp, input int got);
        num_checks++;
        if (got != exp) begin
            n_mismatch++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chkn

    // line 0 of the pins is the most significant bit
    function automatic logic [7:0] rev(input logic [7:0] b);
        for (int i = 0; i < 8; i++) rev[i] = b[7-i];
    endfunction : rev

    task automatic wr(input logic [7:0] b);
        pcp_host_model_inst.sel(1'b0, 1'b0, b);
        pcp_host_model_inst.tick();
    endtask : wr

    task automatic pop_chk(input logic [7:0] exp);
        @(posedge mclk_i);
        #DLY;
        chk1("cfg_valid", 1'b1, cfg_valid_o);
        chk8("cfg_byte", exp, cfg_byte_o);
        cfg_ready_i = 1'b1;
        @(posedge mclk_i);
        #DLY;
        cfg_ready_i = 1'b0;
    endtask : pop_chk

    task automatic t_reset_init();
        int n;
        n = 0;
        pcp_host_model_inst.hold_init = 1'b1;
        repeat (3) @(posedge mclk_i);
        #DLY;
        chk1("done_oe_in_reset", 1'b1, done_oe_o);
        chk1("done_in_reset", 1'b0, done_o);
        rst_n_i = 1'b1;
        for (int i = 0; i < 12; i++) begin
            @(posedge mclk_i);
            #DLY;
            if (init_oe_o === 1'b1) n++;
        end
        chkn("init_clear_cycles", 8, n);
        wr(8'h55);
        chk1("load_while_init_low", 1'b0, cfg_valid_o);
        pcp_host_model_inst.hold_init = 1'b0;
        repeat (6) @(posedge mclk_i);
    endtask : t_reset_init

    task automatic t_bit_order();
        wr(8'h01);
        wr(8'h35);
        pop_chk(8'h80);
        pop_chk(8'hac);
    endtask : t_bit_order

    task automatic t_deselect();
        pcp_host_model_inst.sel(1'b1, 1'b0, 8'hff);
        // let the pin change reach the enables before looking
        #1;
        chk1("busy_oe_deselected", 1'b0, busy_oe_o);
        chk1("data_oe_deselected", 1'b0, data_oe_o);
        pcp_host_model_inst.tick();
        chk1("load_deselected", 1'b0, cfg_valid_o);
    endtask : t_deselect

    task automatic t_fifo_full();
        for (int i = 0; i < 9; i++) wr(8'h10 + 8'(i));
        chk1("busy_full", 1'b1, busy_o);
        for (int i = 0; i < 8; i++) pop_chk(rev(8'h10 + 8'(i)));
        @(posedge mclk_i);
        #DLY;
        chk1("fifo_empty", 1'b0, cfg_valid_o);
    endtask : t_fifo_full

    task automatic t_readback();
        pcp_host_model_inst.sel(1'b1, 1'b1, 8'h00);
        pcp_host_model_inst.sel(1'b0, 1'b1, 8'h00);
        pcp_host_model_inst.tick();
        chk1("rb_data_oe", 1'b1, data_oe_o);
        chk1("rb_busy_enter", 1'b1, busy_o);
        rb_data_i = 8'hc5;
        rb_valid_i = 1'b1;
        pcp_host_model_inst.tick();
        rb_valid_i = 1'b0;
        chk8("rb_pins", 8'ha3, data_i);
        chk1("rb_busy_valid", 1'b0, busy_o);
        chkn("rb_ready_pulses", 1, n_rb_take);
        pcp_host_model_inst.sel(1'b1, 1'b1, 8'h00);
        #1;
        chk1("rb_data_released", 1'b0, data_oe_o);
        chk1("rb_busy_released", 1'b0, busy_oe_o);
        chkn("no_abort_when_deselected", 0, n_abort);
    endtask : t_readback

    task automatic t_abort();
        wr(8'h5a);
        pcp_host_model_inst.sel(1'b0, 1'b1, 8'h5a);
        pcp_host_model_inst.tick();
        chkn("abort_pulses", 1, n_abort);
        chk1("abort_busy", 1'b1, busy_o);
        pcp_host_model_inst.sel(1'b1, 1'b0, 8'h00);
        pop_chk(8'h5a);
    endtask : t_abort

    task automatic t_startup();
        wr(8'h99);
        cfg_end_i = 1'b1;
        pcp_host_model_inst.tick();
        repeat (7) pcp_host_model_inst.tick();
        chk1("done_early", 1'b0, done_o);
        pcp_host_model_inst.tick();
        chk1("done_set", 1'b1, done_o);
        chk1("done_open_drain", 1'b0, done_oe_o);
        cfg_end_i = 1'b0;
        pop_chk(8'h99);
    endtask : t_startup

    task automatic t_crc();
        @(posedge mclk_i);
        #DLY;
        crc_error_i = 1'b1;
        @(posedge mclk_i);
        #DLY;
        crc_error_i = 1'b0;
        repeat (10) @(posedge mclk_i);
        chk1("crc_init_low", 1'b0, init_i);
    endtask : t_crc

    task automatic t_master();
        int   n;
        logic prev;
        n = 0;
        mode_master_i = 1'b1;
        complete_active_driver_i = 1'b1;
        pcp_host_model_inst.sel(1'b0, 1'b0, 8'h0f);
        full_reset_n_i = 1'b0;
        #20;
        chk1("async_reset_init", 1'b0, init_oe_o);
        chk1("async_reset_busy", 1'b1, busy_o);
        repeat (3) @(posedge mclk_i);
        #DLY;
        full_reset_n_i = 1'b1;
        repeat (20) @(posedge mclk_i);
        #DLY;
        chk1("master_clk_oe", 1'b1, config_clock_oe_o);
        chk1("done_active", 1'b1, done_oe_o);
        prev = config_clock_o;
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk_i);
            #DLY;
            if (config_clock_o !== prev) n++;
            prev = config_clock_o;
        end
        chkn("master_clk_toggles", 4, n);
        chk8("master_byte", 8'hf0, cfg_byte_o);
        chk1("master_mode", 1'b1, master_mode_o);
    endtask : t_master

    task automatic end_of_test();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        t_reset_init();
        t_bit_order();
        t_deselect();
        t_fifo_full();
        t_readback();
        t_abort();
        t_startup();
        t_crc();
        t_master();
        end_of_test();
    end

    // the sequence needs about 340 cycles; some fifteen times that means a hang
    initial begin
        repeat (5000) @(posedge mclk_i);
        n_mismatch++;
        end_of_test();
    end
endmodule : pcp_parallel_config_port_test
